// ### design/ris_regbank.v

`include "ris_regbank_consts.vh"

`default_nettype none

module ris_regbank (
    input  wire        mclk,            // 20 MHz system clock
    input  wire        rst_b,           // synchronous reset, active low
    // Register access from the serial control port engine
    input  wire [9:0]  reg_addr,        // register address
    input  wire        reg_wr,          // one-cycle write strobe
    input  wire [7:0]  reg_wdata,       // write data
    input  wire        reg_rd,          // one-cycle read strobe
    output reg  [7:0]  reg_rdata_q,     // read data, valid after reg_rd
    output reg         reg_rvalid_q,    // read data valid pulse
    // Event sources on the system clock (one-cycle pulses)
    input  wire        evt_powerup,     // chip ready for access
    input  wire        evt_ctrl_idle,   // controller accepts a command
    input  wire        evt_por,         // power-on reset seen
    input  wire        evt_rx_sfd,      // delimiter detected
    input  wire        evt_tx_sfd,      // delimiter sent
    input  wire        evt_rx_pkt,      // packet in receive buffer
    input  wire        evt_tx_done,     // transmission complete
    input  wire        evt_cca_valid,   // channel assessment valid
    // Inputs from other domains
    input  wire        wake_timeout,    // wake-up timer expired level
    input  wire        batt_below,      // supply below trip comparator
    // Interrupt enable masks held outside this block
    input  wire [7:0]  irq1_sys_mask,   // line 1 mask, system flags
    input  wire [7:0]  irq1_pkt_mask,   // line 1 mask, packet flags
    input  wire [7:0]  irq2_sys_mask,   // line 2 mask, system flags
    input  wire [7:0]  irq2_pkt_mask,   // line 2 mask, packet flags
    output reg         irq1_q,          // interrupt line 1, active high
    output reg         irq2_q,          // interrupt line 2, active high
    // Configuration outputs
    output wire [1:0]  pad_slew,        // pad slew rate code
    output wire [1:0]  pad_drive,       // pad drive strength code
    output wire [4:0]  batt_trip_code,  // battery comparator trip code
    output wire        tx_tone_only,    // transmit unmodulated carrier
    output wire [3:0]  sfd_symbol_1,    // first delimiter symbol
    output wire [3:0]  sfd_symbol_2     // second delimiter symbol
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function hit;
        input [9:0] addr;
        input [9:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    wire wr_sys  = reg_wr && hit(reg_addr, `RIS_OFS_SYS_EVT);
    wire wr_pkt  = reg_wr && hit(reg_addr, `RIS_OFS_PKT_EVT);
    wire wr_pad  = reg_wr && hit(reg_addr, `RIS_OFS_PAD_DRV);
    wire wr_batt = reg_wr && hit(reg_addr, `RIS_OFS_BATT_THR);
    wire wr_tx   = reg_wr && hit(reg_addr, `RIS_OFS_TX_TEST);
    wire wr_sfd  = reg_wr && hit(reg_addr, `RIS_OFS_SFD_SYM);

    // ------------------------------------------------------------
    // Synchronise the timer and comparator levels
    // ------------------------------------------------------------
    wire [1:0] async_lvl;

    ris_sync3 #(
        .WIDTH    (2)
    ) u_sync (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .async_in ({batt_below, wake_timeout}),
        .level_q  (async_lvl)
    );

    reg wake_prev_q;
    reg batt_prev_q;

    always @(posedge mclk) begin
        if (!rst_b) begin
            wake_prev_q <= 1'b0;
            batt_prev_q <= 1'b0;
        end else begin
            wake_prev_q <= async_lvl[0];
            batt_prev_q <= async_lvl[1];
        end
    end

    wire wake_rise = async_lvl[0] && !wake_prev_q;
    // Falling below the trip point is one event; staying low does not
    // refire after software clears the flag.
    wire batt_rise = async_lvl[1] && !batt_prev_q;

    // ------------------------------------------------------------
    // Sticky event flags
    // ------------------------------------------------------------
    reg  [7:0] sys_q;
    reg  [7:0] sys_d;
    reg  [7:0] pkt_q;
    reg  [7:0] pkt_d;
    reg  [7:0] sys_set;
    reg  [7:0] pkt_set;

    always @* begin
        sys_set = 8'h00;
        sys_set[`RIS_SYS_POWERUP_BIT]   = evt_powerup;
        sys_set[`RIS_SYS_WAKEUP_BIT]    = wake_rise;
        sys_set[`RIS_SYS_CTRL_IDLE_BIT] = evt_ctrl_idle;
        sys_set[`RIS_SYS_POR_BIT]       = evt_por;
        sys_set[`RIS_SYS_BATT_BIT]      = batt_rise;
        pkt_set = 8'h00;
        pkt_set[`RIS_PKT_CCA_BIT]     = evt_cca_valid;
        pkt_set[`RIS_PKT_RX_SFD_BIT]  = evt_rx_sfd;
        pkt_set[`RIS_PKT_TX_SFD_BIT]  = evt_tx_sfd;
        pkt_set[`RIS_PKT_RX_PKT_BIT]  = evt_rx_pkt;
        pkt_set[`RIS_PKT_TX_DONE_BIT] = evt_tx_done;
    end

    // Write one to clear; a set in the same cycle wins.
    always @* begin
        sys_d = sys_q;
        if (wr_sys) begin
            sys_d = sys_q & ~reg_wdata;
        end
        sys_d = (sys_d | sys_set) & `RIS_SYS_LIVE_MASK;
        pkt_d = pkt_q;
        if (wr_pkt) begin
            pkt_d = pkt_q & ~reg_wdata;
        end
        pkt_d = (pkt_d | pkt_set) & `RIS_PKT_LIVE_MASK;
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            sys_q <= `RIS_RST_SYS_EVT;
            pkt_q <= `RIS_RST_PKT_EVT;
        end else begin
            sys_q <= sys_d;
            pkt_q <= pkt_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt lines: flags gated by the external masks
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_b) begin
            irq1_q <= 1'b0;
            irq2_q <= 1'b0;
        end else begin
            irq1_q <= |(sys_q & irq1_sys_mask)
                    | |(pkt_q & irq1_pkt_mask);
            irq2_q <= |(sys_q & irq2_sys_mask)
                    | |(pkt_q & irq2_pkt_mask);
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Reserved bits are stored as written so that a read returns
    // what software put there; they steer nothing.
    reg [7:0] pad_q;
    reg [7:0] batt_q;
    reg [7:0] tx_q;
    reg [7:0] sfd_q;

    always @(posedge mclk) begin
        if (!rst_b) begin
            pad_q  <= `RIS_RST_PAD_DRV;
            batt_q <= `RIS_RST_BATT_THR;
            tx_q   <= `RIS_RST_TX_TEST;
            sfd_q  <= `RIS_RST_SFD_SYM;
        end else begin
            if (wr_pad) begin
                pad_q <= reg_wdata;
            end
            if (wr_batt) begin
                batt_q <= reg_wdata;
            end
            if (wr_tx) begin
                tx_q <= reg_wdata;
            end
            if (wr_sfd) begin
                // Takes effect at once; the radio must be idle.
                sfd_q <= reg_wdata;
            end
        end
    end

    assign pad_slew       = pad_q[`RIS_PAD_SLEW_HI:`RIS_PAD_SLEW_LO];
    // Reserved code 3 is passed through; the pad cell decides.
    assign pad_drive      = pad_q[`RIS_PAD_DRIVE_HI:`RIS_PAD_DRIVE_LO];
    assign batt_trip_code = batt_q[`RIS_BATT_TRIP_HI:`RIS_BATT_TRIP_LO];
    assign tx_tone_only   = tx_q[`RIS_TX_TONE_BIT];
    assign sfd_symbol_2   = sfd_q[`RIS_SFD_SYM2_HI:`RIS_SFD_SYM2_LO];
    assign sfd_symbol_1   = sfd_q[`RIS_SFD_SYM1_HI:`RIS_SFD_SYM1_LO];

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    reg [7:0] rdata_d;

    always @* begin
        case (reg_addr)
            `RIS_OFS_SYS_EVT:  rdata_d = sys_q;
            `RIS_OFS_PKT_EVT:  rdata_d = pkt_q;
            `RIS_OFS_PAD_DRV:  rdata_d = pad_q;
            `RIS_OFS_BATT_THR: rdata_d = batt_q;
            `RIS_OFS_TX_TEST:  rdata_d = tx_q;
            `RIS_OFS_SFD_SYM:  rdata_d = sfd_q;
            default:           rdata_d = `RIS_READ_UNMAPPED;
        endcase
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            reg_rdata_q  <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd) begin
                reg_rdata_q <= rdata_d;
            end
        end
    end

endmodule

`default_nettype wire

// ### design/ris_regbank_consts.vh
`ifndef RIS_REGBANK_CONSTS_VH
`define RIS_REGBANK_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (10-bit address of the serial control port)
// ----------------------------------------------------------------
`define RIS_ADDR_W              10
`define RIS_OFS_SYS_EVT         10'h3CB
`define RIS_OFS_PKT_EVT         10'h3CC
`define RIS_OFS_PAD_DRV         10'h3E3
`define RIS_OFS_BATT_THR        10'h3E6
`define RIS_OFS_TX_TEST         10'h3F0
`define RIS_OFS_SFD_SYM         10'h3F4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RIS_RST_SYS_EVT         8'h00
`define RIS_RST_PKT_EVT         8'h00
`define RIS_RST_PAD_DRV         8'h00
`define RIS_RST_BATT_THR        8'h00
`define RIS_RST_TX_TEST         8'h08
`define RIS_RST_SFD_SYM         8'hA7
`define RIS_READ_UNMAPPED       8'h00

// ----------------------------------------------------------------
// System event flag bits
// ----------------------------------------------------------------
`define RIS_SYS_POWERUP_BIT     1
`define RIS_SYS_WAKEUP_BIT      2
`define RIS_SYS_CTRL_IDLE_BIT   3
`define RIS_SYS_POR_BIT         4
`define RIS_SYS_BATT_BIT        5
`define RIS_SYS_LIVE_MASK       8'h3E

// ----------------------------------------------------------------
// Packet event flag bits
// ----------------------------------------------------------------
`define RIS_PKT_CCA_BIT         0
`define RIS_PKT_RX_SFD_BIT      1
`define RIS_PKT_TX_SFD_BIT      2
`define RIS_PKT_RX_PKT_BIT      3
`define RIS_PKT_TX_DONE_BIT     4
`define RIS_PKT_LIVE_MASK       8'h1F

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define RIS_PAD_SLEW_HI         3
`define RIS_PAD_SLEW_LO         2
`define RIS_PAD_DRIVE_HI        1
`define RIS_PAD_DRIVE_LO        0
`define RIS_PAD_DRIVE_RSVD      2'h3
`define RIS_BATT_TRIP_HI        4
`define RIS_BATT_TRIP_LO        0
`define RIS_TX_TONE_BIT         1
`define RIS_SFD_SYM2_HI         7
`define RIS_SFD_SYM2_LO         4
`define RIS_SFD_SYM1_HI         3
`define RIS_SFD_SYM1_LO         0

// ----------------------------------------------------------------
// Battery trip voltage: base plus step times trip code, in mV
// ----------------------------------------------------------------
`define RIS_BATT_BASE_MV        1700
`define RIS_BATT_STEP_MV        62

`endif

// ### design/ris_sync3.v
`default_nettype none

// ----------------------------------------------------------------
// Three-flop input synchroniser with agreement filter
// ----------------------------------------------------------------
module ris_sync3 #(
    parameter WIDTH = 1
) (
    input  wire             mclk,      // system clock
    input  wire             rst_b,     // synchronous reset, active low
    input  wire [WIDTH-1:0] async_in,  // levels from another domain
    output reg  [WIDTH-1:0] level_q    // filtered level, mclk domain
);

    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;

    // The first stage feeds only the second, so metastability never
    // reaches any decision logic.
    always @(posedge mclk) begin
        if (!rst_b) begin
            s1_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
            s3_q <= {WIDTH{1'b0}};
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_agree
            always @(posedge mclk) begin
                if (!rst_b) begin
                    level_q[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ### sim/ris_regbank_properties.sv
`include "ris_regbank_consts.vh"
`default_nettype none
module ris_regbank_properties (
    input wire logic       mclk,           // clock
    input wire logic       rst_b,          // reset, active low
    input wire logic [9:0] reg_addr,       // address
    input wire logic       reg_wr,         // write strobe
    input wire logic [7:0] reg_wdata,      // write data
    input wire logic       reg_rd,         // read strobe
    input wire logic [7:0] reg_rdata_q,    // read data
    input wire logic       evt_ctrl_idle,  // idle event
    input wire logic       evt_rx_pkt,     // rx packet event
    input wire logic       evt_cca_valid,  // cca event
    input wire logic [7:0] irq1_pkt_mask,  // line 1 mask
    input wire logic       irq1_q,         // line 1
    input wire logic       tx_tone_only,   // tone out
    input wire logic [1:0] pad_slew,       // slew
    input wire logic [1:0] pad_drive,      // drive
    input wire logic [4:0] batt_trip_code, // trip code
    input wire logic [3:0] sfd_symbol_1,   // symbol 1
    input wire logic [3:0] sfd_symbol_2    // symbol 2
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wd_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    always @(posedge mclk) wd_q <= reg_wdata;
    // ------------------------------------------------------------
    // Sticky flags; assumes no clear write between event and read
    // ------------------------------------------------------------
    AST_CTRL_IDLE: assert property (
        reg_rd && reg_addr == `RIS_OFS_SYS_EVT && $past(evt_ctrl_idle, 2)
        |=> reg_rdata_q[3]) else $error("idle flag missing");
    AST_RX_PKT: assert property (
        reg_rd && reg_addr == `RIS_OFS_PKT_EVT && $past(evt_rx_pkt, 2)
        |=> reg_rdata_q[3]) else $error("rx packet flag missing");
    AST_CCA: assert property (
        reg_rd && reg_addr == `RIS_OFS_PKT_EVT && $past(evt_cca_valid, 2)
        |=> reg_rdata_q[0]) else $error("cca flag missing");
    AST_IRQ1: assert property (
        evt_rx_pkt && irq1_pkt_mask[3] |-> ##2 irq1_q)
        else $error("irq line 1 not raised");
    // ------------------------------------------------------------
    // Configuration fields follow writes
    // ------------------------------------------------------------
    AST_TONE: assert property (
        reg_wr && reg_addr == `RIS_OFS_TX_TEST |=> tx_tone_only == wd_q[1])
        else $error("tone bit wrong");
    AST_SFD: assert property (
        reg_wr && reg_addr == `RIS_OFS_SFD_SYM
        |=> {sfd_symbol_2, sfd_symbol_1} == wd_q) else $error("sfd wrong");
    AST_PAD: assert property (
        reg_wr && reg_addr == `RIS_OFS_PAD_DRV
        |=> {pad_slew, pad_drive} == wd_q[3:0]) else $error("pad wrong");
    AST_BATT: assert property (
        reg_wr && reg_addr == `RIS_OFS_BATT_THR
        |=> batt_trip_code == wd_q[4:0]) else $error("trip code wrong");
endmodule
bind ris_regbank ris_regbank_properties u_props (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .evt_ctrl_idle(evt_ctrl_idle), .evt_rx_pkt(evt_rx_pkt),
    .evt_cca_valid(evt_cca_valid), .irq1_pkt_mask(irq1_pkt_mask),
    .irq1_q(irq1_q), .tx_tone_only(tx_tone_only), .pad_slew(pad_slew),
    .pad_drive(pad_drive), .batt_trip_code(batt_trip_code),
    .sfd_symbol_1(sfd_symbol_1), .sfd_symbol_2(sfd_symbol_2));
`default_nettype wire

// ### sim/tb.sv
`include "ris_regbank_consts.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0, wake = 1'b0;
    logic batt = 1'b0, rvalid, irq1, irq2, tone;
    logic [9:0] addr = 10'h000;
    logic [7:0] wdata = 8'h00, ev = 8'h00, m1s = 8'h00, m1p = 8'h00;
    logic [7:0] m2s = 8'h00, m2p = 8'h00, rdata;
    logic [1:0] slew, drv;
    logic [4:0] trip;
    logic [3:0] s1, s2;
    int err_count = 0, tests_run = 0;
    ris_regbank u_ris_regbank (
        .mclk(mclk), .rst_b(rst_b), .reg_addr(addr), .reg_wr(wr_s),
        .reg_wdata(wdata), .reg_rd(rd_s), .reg_rdata_q(rdata),
        .reg_rvalid_q(rvalid), .evt_powerup(ev[5]), .evt_ctrl_idle(ev[6]),
        .evt_por(ev[7]), .evt_rx_sfd(ev[1]), .evt_tx_sfd(ev[2]),
        .evt_rx_pkt(ev[3]), .evt_tx_done(ev[4]), .evt_cca_valid(ev[0]),
        .wake_timeout(wake), .batt_below(batt), .irq1_sys_mask(m1s),
        .irq1_pkt_mask(m1p), .irq2_sys_mask(m2s), .irq2_pkt_mask(m2p),
        .irq1_q(irq1), .irq2_q(irq2), .pad_slew(slew), .pad_drive(drv),
        .batt_trip_code(trip), .tx_tone_only(tone), .sfd_symbol_1(s1),
        .sfd_symbol_2(s2));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr_s <= 1'b0;
        #1;
    endtask
    // The valid pulse stands one cycle only, so it is judged right here
    task automatic rd(input logic [9:0] a, input logic [7:0] e, string n);
        @(posedge mclk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1;
        chk("rvalid", 8'h01, {7'h00, rvalid});
        chk(n, e, rdata);
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= 8'h00;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(`RIS_OFS_SYS_EVT, `RIS_RST_SYS_EVT, "sys");
        rd(`RIS_OFS_PKT_EVT, `RIS_RST_PKT_EVT, "pkt");
        rd(`RIS_OFS_PAD_DRV, `RIS_RST_PAD_DRV, "pad");
        rd(`RIS_OFS_BATT_THR, `RIS_RST_BATT_THR, "batt");
        rd(`RIS_OFS_TX_TEST, `RIS_RST_TX_TEST, "txtest");
        rd(`RIS_OFS_SFD_SYM, `RIS_RST_SFD_SYM, "sfd");
        chk("sym1", 8'h07, {4'h0, s1});
        $display("reset test done");
    endtask
    task automatic t_config;
        for (int i = 0; i < 4; i++) begin
            wr(`RIS_OFS_PAD_DRV, {4'h0, 2'(i), 2'(3 - i)});
            chk("slew", 8'(i), {6'h00, slew});
            chk("drive", 8'(3 - i), {6'h00, drv});
        end
        wr(`RIS_OFS_BATT_THR, 8'h1F);
        chk("trip", 8'h1F, {3'h0, trip});
        wr(`RIS_OFS_TX_TEST, 8'h0A);
        chk("tone on", 8'h01, {7'h00, tone});
        rd(`RIS_OFS_TX_TEST, 8'h0A, "txtest");
        wr(`RIS_OFS_TX_TEST, 8'h08);
        chk("tone off", 8'h00, {7'h00, tone});
        wr(`RIS_OFS_SFD_SYM, 8'h5C);
        chk("sym2", 8'h05, {4'h0, s2});
        chk("sym1", 8'h0C, {4'h0, s1});
        wr(10'h3E4, 8'hFF);
        rd(10'h3E4, `RIS_READ_UNMAPPED, "unmapped");
        rd(`RIS_OFS_PAD_DRV, 8'h0C, "pad kept");
        $display("config test done");
    endtask
    task automatic t_sys;
        @(posedge mclk);
        m2s <= 8'h02;
        m1s <= 8'h20;
        pulse(8'hE0);
        rd(`RIS_OFS_SYS_EVT, 8'h1A, "sys evt");
        chk("irq2 on", 8'h01, {7'h00, irq2});
        chk("irq1 sys idle", 8'h00, {7'h00, irq1});
        @(posedge mclk);
        wake <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(`RIS_OFS_SYS_EVT, 8'h1E, "wakeup");
        @(posedge mclk);
        batt <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(`RIS_OFS_SYS_EVT, 8'h3E, "batt alert");
        chk("irq1 sys on", 8'h01, {7'h00, irq1});
        wr(`RIS_OFS_SYS_EVT, 8'h3E);
        rd(`RIS_OFS_SYS_EVT, 8'h00, "sys clear");
        chk("irq2 off", 8'h00, {7'h00, irq2});
        chk("irq1 sys off", 8'h00, {7'h00, irq1});
        $display("system flag test done");
    endtask
    task automatic t_pkt;
        @(posedge mclk);
        m1p <= 8'h08;
        m2p <= 8'h10;
        pulse(8'h1F);
        rd(`RIS_OFS_PKT_EVT, 8'h1F, "pkt evt");
        chk("irq1 on", 8'h01, {7'h00, irq1});
        chk("irq2 pkt on", 8'h01, {7'h00, irq2});
        wr(`RIS_OFS_PKT_EVT, 8'h00);
        rd(`RIS_OFS_PKT_EVT, 8'h1F, "zero write");
        wr(`RIS_OFS_PKT_EVT, 8'h08);
        rd(`RIS_OFS_PKT_EVT, 8'h17, "clear rx");
        chk("irq1 off", 8'h00, {7'h00, irq1});
        chk("irq2 pkt kept", 8'h01, {7'h00, irq2});
        // A clear landing with a new event must not lose the event
        @(posedge mclk);
        ev <= 8'h08;
        wr_s <= 1'b1;
        addr <= `RIS_OFS_PKT_EVT;
        wdata <= 8'h08;
        @(posedge mclk);
        ev <= 8'h00;
        wr_s <= 1'b0;
        rd(`RIS_OFS_PKT_EVT, 8'h1F, "set wins");
        wr(`RIS_OFS_PKT_EVT, 8'h1F);
        rd(`RIS_OFS_PKT_EVT, 8'h00, "pkt clear");
        chk("irq2 pkt off", 8'h00, {7'h00, irq2});
        $display("packet flag test done");
    endtask
    task automatic final_report;
        $display("Checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset;
        t_config;
        t_sys;
        t_pkt;
        final_report;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        final_report;
    end
endmodule
`default_nettype wire
